// >>> mhc_top.sv
// Operation
// R01 - High-pass filter runs on capture path while its enable bit is set, default on.
// R02 - Two-bit cutoff field picks hi-fi DC removal or voice modes one to three.
// R03 - Cutoff is a fixed fraction of the sample rate.
// R04 - Software should keep the voice corner below 300 Hz at its sample rate.
// R05 - Compressor changes no gain while its enable bit is clear.
// R06 - Path bit puts compressor on capture path at 0, playback path at 1.
// R07 - Compressor sits in one path only; the other passes samples untouched.
// R08 - Knee splits curve: upper slope above knee, lower slope below.
// R09 - Slopes act in dB: 1 keeps gain, below 1 compresses, 0 holds level.
// R10 - Knee input code counts down from 0 dB in 0.75 dB steps to -45 dB.
// R11 - Knee output code counts down from 0 dB in 0.75 dB steps to -22.5 dB.
// R12 - Upper slope codes mean 1, 1/2, 1/4, 1/8, 1/16 and 0.
// R13 - Lower slope codes mean 1, 1/2, 1/4, 1/8 and 0.
// R14 - Output for 0 dB input is knee output minus knee input times upper slope.
// R15 - Level detection follows mean-square amplitude over time, not single peaks.
// R16 - Disabled filter passes samples bit-exact and holds its history cleared.
// R17 - Reserved slope or knee codes act as the nearest valid extreme.
//
// Local design decision: the APB interface to the registers.
module mhc_top (
  input  wire logic        pclk,           // Clock, 200 MHz
  input  wire logic        presetn,        // Async reset, active low
  input  wire logic        psel,           // APB select
  input  wire logic        penable,        // APB enable
  input  wire logic        pwrite,         // APB direction
  input  wire logic [7:0]  paddr,          // APB byte address
  input  wire logic [31:0] pwdata,         // APB write data
  output logic      [31:0] prdata,         // APB read data
  output logic             pready,         // APB ready
  output logic             pslverr,        // APB error
  input  wire logic        mic_in_valid,   // Capture sample valid
  output logic             mic_in_ready,   // Capture sample taken
  input  wire logic [15:0] mic_in_data,    // Capture sample
  output logic             mic_out_valid,  // Processed capture valid
  input  wire logic        mic_out_ready,  // Downstream takes capture
  output logic      [15:0] mic_out_data,   // Processed capture sample
  input  wire logic        dac_in_valid,   // Playback sample valid
  output logic             dac_in_ready,   // Playback sample taken
  input  wire logic [15:0] dac_in_data,    // Playback sample
  output logic             dac_out_valid,  // Processed playback valid
  input  wire logic        dac_out_ready,  // Downstream takes playback
  output logic      [15:0] dac_out_data    // Processed playback sample
);

  function automatic logic signed [15:0] sat16(input logic signed [49:0] v);
    if (v > 50'(mhc_pkg::OUT_MAX))
      return mhc_pkg::OUT_MAX;
    else if (v < 50'(mhc_pkg::OUT_MIN))
      return mhc_pkg::OUT_MIN;
    else
      return v[15:0];
  endfunction

  function automatic logic [4:0] msb_pos(input logic [30:0] v);
    logic [4:0] p;
    p = '0;
    for (int i = 0; i < 31; i++) begin
      if (v[i])
        p = 5'(i);
    end
    return p;
  endfunction

  // Control registers
  logic       hpf_en;
  logic [1:0] hpf_cut;
  logic       cmp_en;
  logic       cmp_path;
  logic [2:0] hi_code;
  logic [2:0] lo_code;
  logic [5:0] ki_code;
  logic [4:0] ko_code;

  // APB decode
  wire sel_mic   = (paddr == mhc_pkg::ADDR_MIC_FILTER);
  wire sel_main  = (paddr == mhc_pkg::ADDR_CMP_MAIN);
  wire sel_slope = (paddr == mhc_pkg::ADDR_CMP_SLOPE);
  wire sel_knee  = (paddr == mhc_pkg::ADDR_CMP_KNEE);
  wire sel_stat  = (paddr == mhc_pkg::ADDR_CMP_STATUS);
  wire mapped    = sel_mic | sel_main | sel_slope | sel_knee | sel_stat;
  wire apb_acc   = psel & penable;
  wire apb_setup = psel & ~penable;
  wire reg_wr    = apb_acc & pwrite & mapped;

  // Zero wait states: read data is captured in the setup cycle
  assign pready  = apb_acc;
  assign pslverr = apb_acc & ~mapped;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hpf_en   <= mhc_pkg::HPF_EN_RST;
      hpf_cut  <= mhc_pkg::HPF_CUT_RST;
      cmp_en   <= mhc_pkg::CMP_EN_RST;
      cmp_path <= mhc_pkg::CMP_PATH_RST;
      hi_code  <= mhc_pkg::HI_RST;
      lo_code  <= mhc_pkg::LO_RST;
      ki_code  <= mhc_pkg::KI_RST;
      ko_code  <= mhc_pkg::KO_RST;
    end else if (reg_wr) begin
      if (sel_mic) begin
        hpf_en  <= pwdata[mhc_pkg::HPF_EN_BIT];
        hpf_cut <= pwdata[mhc_pkg::HPF_CUT_LSB +: 2];
      end
      if (sel_main) begin
        cmp_en   <= pwdata[mhc_pkg::CMP_EN_BIT];
        cmp_path <= pwdata[mhc_pkg::CMP_PATH_BIT];
      end
      if (sel_slope) begin
        hi_code <= pwdata[mhc_pkg::HI_LSB +: 3];
        lo_code <= pwdata[mhc_pkg::LO_LSB +: 3];
      end
      if (sel_knee) begin
        ki_code <= pwdata[mhc_pkg::KI_LSB +: 6];
        ko_code <= pwdata[mhc_pkg::KO_LSB +: 5];
      end
    end
  end

  // Stream handshakes
  wire mic_acc     = mic_in_valid & mic_in_ready;
  wire dac_acc     = dac_in_valid & dac_in_ready;
  wire cmp_on_mic  = cmp_en & ~cmp_path; // R06
  wire cmp_on_dac  = cmp_en & cmp_path;  // R07
  wire cmp_acc     = cmp_path ? dac_acc : mic_acc;

  // Capture high-pass: y = x - x1 + y1 - y1/2^k, with extra fraction bits
  logic signed [15:0] x_prev;
  logic signed [25:0] y_acc;
  wire signed  [15:0] mic_x    = $signed(mic_in_data);
  wire         [3:0]  hpf_k    = mhc_pkg::HPF_SHIFT[hpf_cut]; // R03
  wire signed  [16:0] hpf_dx   = 17'(mic_x) - 17'(x_prev);
  wire signed  [25:0] hpf_next = y_acc - (y_acc >>> hpf_k) + (26'(hpf_dx) <<< mhc_pkg::HPF_FRAC); // R02
  wire signed  [15:0] hpf_y    = sat16(50'(hpf_next >>> mhc_pkg::HPF_FRAC));
  wire signed  [15:0] hpf_out  = hpf_en ? hpf_y : mic_x; // R01

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      x_prev <= '0;
      y_acc  <= '0;
    end else if (!hpf_en) begin
      // Restart from zero history so re-enable has no stale step
      x_prev <= '0; // R16
      y_acc  <= '0;
    end else if (mic_acc) begin
      x_prev <= mic_x;
      y_acc  <= hpf_next;
    end
  end

  // Mean-square level detector, one update per sample of the active path
  logic        [30:0] ms;
  wire signed  [15:0] cmp_x   = cmp_path ? $signed(dac_in_data) : hpf_out;
  wire         [30:0] sq      = 31'($unsigned(32'(cmp_x) * 32'(cmp_x)));
  wire signed  [32:0] ms_diff = $signed({2'h0, sq}) - $signed({2'h0, ms});
  wire         [30:0] ms_next = ms + 31'(ms_diff >>> mhc_pkg::RMS_SHIFT); // R15

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      ms <= '0;
    else if (!cmp_en)
      ms <= '0; // R05
    else if (cmp_acc)
      ms <= ms_next;
  end

  // Level below full scale in 0.75 dB steps: about 4 * log2 of mean square
  wire [4:0]  ms_pos  = msb_pos(ms);
  wire [30:0] ms_norm = ms << (5'h1E - ms_pos);
  wire [6:0]  ms_log4 = {ms_pos, ms_norm[29:28]};
  wire [6:0]  level   = (ms == '0) ? mhc_pkg::LEVEL_SILENT :
                        (ms_log4 >= mhc_pkg::LEVEL_FULL) ? 7'h00 :
                        mhc_pkg::LEVEL_FULL - ms_log4;

  // Reserved codes fold onto the nearest valid extreme
  wire [5:0] ki     = (ki_code > mhc_pkg::KI_MAX) ? mhc_pkg::KI_MAX : ki_code;   // R10 R17
  wire [4:0] ko     = (ko_code > mhc_pkg::KO_MAX) ? mhc_pkg::KO_MAX : ko_code;   // R11 R17
  wire [2:0] hi_eff = (hi_code > mhc_pkg::HI_ZERO) ? mhc_pkg::HI_ZERO : hi_code; // R12 R17
  wire [2:0] lo_eff = (lo_code > mhc_pkg::LO_ZERO) ? mhc_pkg::LO_ZERO : lo_code; // R13 R17

  // Static curve in steps below full scale; slopes are right shifts
  wire signed [9:0] knee_d  = $signed({3'h0, level}) - $signed({4'h0, ki});
  wire              above   = (knee_d <= 10'sh000); // R08
  wire        [2:0] sh      = above ? hi_eff : lo_eff;
  wire              flat    = above ? (hi_eff == mhc_pkg::HI_ZERO) : (lo_eff == mhc_pkg::LO_ZERO); // R09
  wire signed [9:0] knee_m  = knee_d[9] ? -knee_d : knee_d;
  wire signed [9:0] knee_s  = knee_m >>> sh;
  // Rounds toward zero so the 0 dB point matches the knee arithmetic exactly
  wire signed [9:0] knee_t  = flat ? 10'sh000 : (knee_d[9] ? -knee_s : knee_s);
  wire signed [9:0] out_lvl = $signed({5'h00, ko}) + knee_t; // R14
  wire signed [9:0] gain_st = $signed({3'h0, level}) - out_lvl;
  wire signed [7:0] gain8   = (gain_st > mhc_pkg::GAIN_MAX) ? mhc_pkg::GAIN_MAX[7:0] :
                              (gain_st < mhc_pkg::GAIN_MIN) ? mhc_pkg::GAIN_MIN[7:0] : gain_st[7:0];

  // Gain 2^(g/8): mantissa from the low bits, shift from the high bits
  wire signed [4:0]  gain_int = $signed(gain8[7:3]);
  wire        [15:0] mant     = mhc_pkg::GAIN_MANT[gain8[2:0]];
  wire signed [32:0] prod     = 33'(cmp_x) * $signed({1'h0, mant});
  wire signed [49:0] prod_up  = 50'(prod) <<< 16;
  wire        [5:0]  rs       = 6'(mhc_pkg::GAIN_BIAS - 7'(gain_int));
  wire signed [15:0] cmp_y    = sat16(prod_up >>> rs);

  // Capture path into the FIFO; a full FIFO stalls the source
  mhc_stream_if #(.W(mhc_pkg::SAMPLE_W)) fifo_in ();
  mhc_stream_if #(.W(mhc_pkg::SAMPLE_W)) fifo_out ();

  assign fifo_in.valid  = mic_in_valid;
  assign fifo_in.data   = cmp_on_mic ? cmp_y : hpf_out; // R07
  assign mic_in_ready   = fifo_in.ready;
  assign mic_out_valid  = fifo_out.valid;
  assign mic_out_data   = fifo_out.data;
  assign fifo_out.ready = mic_out_ready;

  mhc_fifo #(
    .W     (mhc_pkg::SAMPLE_W),
    .DEPTH (mhc_pkg::FIFO_DEPTH)
  ) u_fifo (
    .pclk    (pclk),
    .presetn (presetn),
    .wr      (fifo_in),
    .rd      (fifo_out)
  );

  // Playback path, one output register
  // Output stands until taken, so a stalled sink loses nothing
  assign dac_in_ready = ~dac_out_valid | dac_out_ready;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dac_out_valid <= 1'h0;
      dac_out_data  <= 16'h0000;
    end else if (dac_acc) begin
      dac_out_valid <= 1'h1;
      dac_out_data  <= cmp_on_dac ? cmp_y : dac_in_data; // R07
    end else if (dac_out_ready) begin
      dac_out_valid <= 1'h0;
    end
  end

  // Read back
  wire [15:0] rd_mic   = (16'(hpf_en) << mhc_pkg::HPF_EN_BIT) | (16'(hpf_cut) << mhc_pkg::HPF_CUT_LSB);
  wire [15:0] rd_main  = (16'(cmp_en) << mhc_pkg::CMP_EN_BIT) | (16'(cmp_path) << mhc_pkg::CMP_PATH_BIT);
  wire [15:0] rd_slope = (16'(hi_code) << mhc_pkg::HI_LSB) | (16'(lo_code) << mhc_pkg::LO_LSB);
  wire [15:0] rd_knee  = (16'(ki_code) << mhc_pkg::KI_LSB) | (16'(ko_code) << mhc_pkg::KO_LSB);
  wire [15:0] rd_stat  = (16'($unsigned(gain8)) << mhc_pkg::STAT_GAIN_LSB) | 16'(level);
  wire [15:0] rd_word  = sel_mic   ? rd_mic   :
                         sel_main  ? rd_main  :
                         sel_slope ? rd_slope :
                         sel_knee  ? rd_knee  :
                         sel_stat  ? rd_stat  : 16'h0000;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      prdata <= 32'h0000_0000;
    else if (apb_setup && !pwrite)
      prdata <= {16'h0000, rd_word};
  end

  // Checks
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  AST_HPF_BYPASS: assert property ( // R16
    mic_acc && !hpf_en && !cmp_on_mic |-> fifo_in.data == mic_in_data)
    else $error("disabled filter altered capture sample");

  AST_HPF_CLEARED: assert property ( // R16
    $fell(hpf_en) |=> (x_prev == 16'sh0000) && (y_acc == 26'sh0000000) [*2])
    else $error("filter history not cleared");

  AST_HPF_DC_ZERO: assert property ( // R01
    mic_acc && hpf_en && !cmp_on_mic && (mic_x == x_prev) && (y_acc == 26'sh0000000)
    |-> fifo_in.data == 16'h0000)
    else $error("filter passed a DC sample");

  AST_MIC_FREE_WHEN_DAC: assert property ( // R06
    mic_acc && cmp_on_dac |-> fifo_in.data == hpf_out)
    else $error("capture sample compressed while compressor is on playback");

  AST_DAC_PASS: assert property ( // R07
    dac_acc && !cmp_on_dac |=> dac_out_valid && (dac_out_data == $past(dac_in_data)))
    else $error("playback sample altered without compressor");

  AST_CMP_OFF_CLEAR: assert property ( // R05
    !cmp_en ##1 !cmp_en |-> ms == 31'h00000000)
    else $error("level detector running while compressor is off");

  AST_RMS_SMOOTH: assert property ( // R15
    cmp_en && cmp_acc && (ms == 31'h00000000) |=> ms <= ($past(sq) >> 6))
    else $error("level detector follows a single peak");

  AST_KNEE_CLAMP: assert property ( // R17
    (ki_code > mhc_pkg::KI_MAX |-> ki == mhc_pkg::KI_MAX) and
    (ko_code > mhc_pkg::KO_MAX |-> ko == mhc_pkg::KO_MAX))
    else $error("reserved knee code not folded");

  AST_FLAT_ABOVE: assert property ( // R09
    above && (hi_eff == mhc_pkg::HI_ZERO) |-> out_lvl == $signed({5'h00, ko}))
    else $error("zero slope does not hold level");

  AST_UNITY_GAIN: assert property ( // R12
    (hi_eff == 3'h0) && (lo_eff == 3'h0) |-> gain_st == $signed({4'h0, ki}) - $signed({5'h00, ko}))
    else $error("unity slopes give a varying gain");

  AST_Y0: assert property ( // R14
    (level == 7'h00) && (hi_eff != mhc_pkg::HI_ZERO)
    |-> out_lvl == $signed({5'h00, ko}) - $signed({4'h0, ki >> hi_eff}))
    else $error("full-scale output level wrong");

  AST_APB_ERR: assert property (
    apb_acc && !mapped |-> pslverr && pready)
    else $error("unmapped access not flagged");

  AST_RD_HOLD: assert property (
    psel && penable && !pwrite |=> $stable(prdata))
    else $error("read data changed after the access cycle");

  AST_PRDATA_UPPER: assert property (
    prdata[31:16] == 16'h0000)
    else $error("read data upper half not zero");

  AST_CMP_OFF_PASS: assert property ( // R05
    mic_acc && !cmp_en |-> fifo_in.data == hpf_out)
    else $error("capture sample gained while compressor is off");

  AST_SLOPE_CLAMP: assert property ( // R17
    (hi_code > mhc_pkg::HI_ZERO |-> hi_eff == mhc_pkg::HI_ZERO) and
    (lo_code > mhc_pkg::LO_ZERO |-> lo_eff == mhc_pkg::LO_ZERO))
    else $error("reserved slope code not folded");

  AST_DAC_HELD: assert property (
    dac_out_valid && !dac_out_ready |=> dac_out_valid && $stable(dac_out_data))
    else $error("playback output dropped before it was taken");

  AST_HPF_RESTART: assert property ( // R16
    $rose(hpf_en) |-> (x_prev == 16'sh0000) && (y_acc == 26'sh0000000))
    else $error("filter restarted with stale history");

  COV_HPF_VOICE3: cover property (mic_acc && hpf_en && (hpf_cut == 2'h3));
  COV_DAC_COMP:   cover property (dac_acc && cmp_on_dac && (gain8 != 8'sh00));
  COV_MIC_STALL:  cover property (mic_in_valid && !mic_in_ready);
  COV_KNEE_FLAT:  cover property (cmp_on_mic && above && (hi_eff == mhc_pkg::HI_ZERO));

endmodule

// >>> mhc_pkg.sv
package mhc_pkg;

  localparam int SAMPLE_W   = 16;
  localparam int FIFO_DEPTH = 4;

  // Register indices; byte address is four times the index
  localparam logic [7:0] IDX_MIC_FILTER = 8'h26;
  localparam logic [7:0] IDX_CMP_MAIN   = 8'h28;
  localparam logic [7:0] IDX_CMP_SLOPE  = 8'h2A;
  localparam logic [7:0] IDX_CMP_KNEE   = 8'h2B;
  localparam logic [7:0] IDX_CMP_STATUS = 8'h2C;
  localparam logic [7:0] ADDR_MIC_FILTER = 8'(IDX_MIC_FILTER * 4);
  localparam logic [7:0] ADDR_CMP_MAIN   = 8'(IDX_CMP_MAIN * 4);
  localparam logic [7:0] ADDR_CMP_SLOPE  = 8'(IDX_CMP_SLOPE * 4);
  localparam logic [7:0] ADDR_CMP_KNEE   = 8'(IDX_CMP_KNEE * 4);
  localparam logic [7:0] ADDR_CMP_STATUS = 8'(IDX_CMP_STATUS * 4);

  // Field positions
  localparam int HPF_EN_BIT   = 4;
  localparam int HPF_CUT_LSB  = 5;
  localparam int CMP_EN_BIT   = 15;
  localparam int CMP_PATH_BIT = 14;
  localparam int HI_LSB       = 3;
  localparam int LO_LSB       = 0;
  localparam int KI_LSB       = 5;
  localparam int KO_LSB       = 0;
  localparam int STAT_GAIN_LSB = 8;

  // Reset values
  localparam logic       HPF_EN_RST   = 1'h1;
  localparam logic [1:0] HPF_CUT_RST  = 2'h0;
  localparam logic       CMP_EN_RST   = 1'h0;
  localparam logic       CMP_PATH_RST = 1'h0;
  localparam logic [2:0] HI_RST       = 3'h0;
  localparam logic [2:0] LO_RST       = 3'h0;
  localparam logic [5:0] KI_RST       = 6'h00;
  localparam logic [4:0] KO_RST       = 5'h00;

  // Valid extremes of the compressor fields
  localparam logic [5:0] KI_MAX  = 6'h3C;
  localparam logic [4:0] KO_MAX  = 5'h1E;
  localparam logic [2:0] HI_ZERO = 3'h5;
  localparam logic [2:0] LO_ZERO = 3'h4;

  // Feedback shift per cutoff mode: corner is about fs/(2*pi*2^k)
  localparam logic [3:0] HPF_SHIFT [4] = '{4'hB, 4'h4, 4'h3, 4'h2};
  localparam int HPF_FRAC = 8;

  localparam int         RMS_SHIFT     = 6;
  localparam logic [6:0] LEVEL_FULL    = 7'h78;
  localparam logic [6:0] LEVEL_SILENT  = 7'h7F;
  localparam logic signed [9:0] GAIN_MAX = 10'sh07F;
  localparam logic signed [9:0] GAIN_MIN = 10'sh380;
  localparam logic signed [6:0] GAIN_BIAS = 7'sh1E;

  // 2^(f/8) in Q1.14, one 0.75 dB step per entry
  localparam logic [15:0] GAIN_MANT [8] = '{16'h4000, 16'h45CB, 16'h4C1C, 16'h52FF,
                                            16'h5A82, 16'h62B4, 16'h6BA2, 16'h7560};

  localparam logic signed [15:0] OUT_MAX = 16'sh7FFF;
  localparam logic signed [15:0] OUT_MIN = 16'sh8000;

endpackage

// >>> mhc_stream_if.sv
interface mhc_stream_if #(parameter int W = 16) ();
  logic         valid;
  logic         ready;
  logic [W-1:0] data;
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface

// >>> mhc_fifo.sv
module mhc_fifo #(
  parameter int W     = 16,
  parameter int DEPTH = 4
) (
  input wire logic    pclk,     // Clock
  input wire logic    presetn,  // Async reset, active low
  mhc_stream_if.snk   wr,       // Filling side
  mhc_stream_if.src   rd        // Draining side
);
  localparam int AW = $clog2(DEPTH);

  logic [W-1:0] mem [DEPTH];
  logic [AW-1:0] wptr;
  logic [AW-1:0] rptr;
  logic [AW:0]   count;

  wire push = wr.valid && wr.ready;
  wire pop  = rd.valid && rd.ready;
  wire [AW-1:0] wptr_inc = (wptr == AW'(DEPTH - 1)) ? '0 : wptr + 1'b1;
  wire [AW-1:0] rptr_inc = (rptr == AW'(DEPTH - 1)) ? '0 : rptr + 1'b1;

  assign wr.ready = (count != (AW + 1)'(DEPTH));
  assign rd.valid = (count != '0);
  assign rd.data  = mem[rptr];

  always_ff @(posedge pclk) begin
    if (push)
      mem[wptr] <= wr.data;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wptr  <= '0;
      rptr  <= '0;
      count <= '0;
    end else begin
      if (push)
        wptr <= wptr_inc;
      if (pop)
        rptr <= rptr_inc;
      if (push && !pop)
        count <= count + 1'b1;
      else if (pop && !push)
        count <= count - 1'b1;
    end
  end

  AST_FIFO_BOUND: assert property (@(posedge pclk) disable iff (!presetn)
    count <= (AW + 1)'(DEPTH))
    else $error("fifo count above depth");
  AST_FIFO_FULL_STALL: assert property (@(posedge pclk) disable iff (!presetn)
    (count == (AW + 1)'(DEPTH)) && !pop |=> !wr.ready)
    else $error("fifo accepts while full");

endmodule

// >>> mhc_sink_model.sv
module mhc_sink_model (
  input  wire logic        pclk,     // Clock
  input  wire logic        presetn,  // Async reset, active low
  input  wire logic        valid,    // Sample offered
  input  wire logic [15:0] data,     // Offered sample
  input  wire logic        hold,     // Refuse every sample once ready has dropped
  input  wire logic        stall,    // Random back-pressure
  output logic             ready     // Sample taken
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] got [$];
  // Ready is registered, so a held sink still takes one sample in flight
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ready <= 1'b0;
    end else begin
      if (valid && ready) begin
        got.push_back(data);
      end
      ready <= !hold && (!stall || $urandom_range(1));
    end
  end
endmodule

// >>> tb_mhc_top.sv
module tb_mhc_top;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [7:0] A_F = mhc_pkg::ADDR_MIC_FILTER;
  localparam logic [7:0] A_M = mhc_pkg::ADDR_CMP_MAIN;
  localparam logic [7:0] A_S = mhc_pkg::ADDR_CMP_SLOPE;
  localparam logic [7:0] A_K = mhc_pkg::ADDR_CMP_KNEE;
  logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic        pready, pslverr, er, hold_m = 1'b0, stall = 1'b0;
  logic        mic_in_valid = 1'b0, mic_in_ready, mic_out_valid, mic_out_ready;
  logic        dac_in_valid = 1'b0, dac_in_ready, dac_out_valid, dac_out_ready;
  logic [15:0] mic_in_data = 16'h0, mic_out_data, dac_in_data = 16'h0, dac_out_data;
  logic [15:0] x, first, last;
  logic [15:0] exp_m [$], exp_d [$];
  int          num_errors = 0, checked = 0, cyc = 0, n;
  real         e;

  mhc_top u_mhc_top (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .mic_in_valid(mic_in_valid), .mic_in_ready(mic_in_ready),
    .mic_in_data(mic_in_data), .mic_out_valid(mic_out_valid), .mic_out_ready(mic_out_ready),
    .mic_out_data(mic_out_data), .dac_in_valid(dac_in_valid), .dac_in_ready(dac_in_ready),
    .dac_in_data(dac_in_data), .dac_out_valid(dac_out_valid), .dac_out_ready(dac_out_ready),
    .dac_out_data(dac_out_data));
  mhc_sink_model u_mhc_sink_model_m (.pclk(pclk), .presetn(presetn), .valid(mic_out_valid),
    .data(mic_out_data), .hold(hold_m), .stall(stall), .ready(mic_out_ready));
  mhc_sink_model u_mhc_sink_model_d (.pclk(pclk), .presetn(presetn), .valid(dac_out_valid),
    .data(dac_out_data), .hold(1'b0), .stall(stall), .ready(dac_out_ready));

  always #2.5 pclk = ~pclk;
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 40000) begin
      num_errors++;
      final_report();
    end
  end

  task final_report();
    $display("errors %0d checks %0d", num_errors, checked);
    if (num_errors == 0 && checked > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  task chk(input string nm, input logic [31:0] ex, input logic [31:0] g);
    checked++;
    if (g !== ex) begin
      num_errors++;
      $display("ERROR %s expected %h seen %h", nm, ex, g);
    end
  endtask

  task chkr(input string nm, input real lo, input real hi, input logic [15:0] g);
    checked++;
    if ($isunknown(g) || !($signed(g) > lo && $signed(g) < hi)) begin
      num_errors++;
      $display("ERROR %s expected %0.1f to %0.1f seen %0d", nm, lo, hi, $signed(g));
    end
  endtask

  // Entered just after a rising edge; leaves just after one
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    penable <= 1'b0;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task rdc(input string nm, input logic [7:0] a, input logic [31:0] ex);
    apb(1'b0, a, 32'h0);
    chk(nm, ex, rd);
  endtask

  // Valid stays up so back-to-back samples never reassign it in one step
  task snd(input bit dac, input logic [15:0] v);
    if (dac) begin
      mic_in_valid <= 1'b0;
      dac_in_valid <= 1'b1;
      dac_in_data <= v;
      exp_d.push_back(v);
    end else begin
      dac_in_valid <= 1'b0;
      mic_in_valid <= 1'b1;
      mic_in_data <= v;
      exp_m.push_back(v);
    end
    do @(posedge pclk); while ((dac ? dac_in_ready : mic_in_ready) !== 1'b1);
  endtask

  // Skipped path is counted only; its first and last samples are kept
  task drain(input int skip);
    mic_in_valid <= 1'b0;
    dac_in_valid <= 1'b0;
    n = 0;
    while ((u_mhc_sink_model_m.got.size() < exp_m.size() ||
            u_mhc_sink_model_d.got.size() < exp_d.size()) && n < 3000) begin
      @(posedge pclk);
      n++;
    end
    chk("mic_count", exp_m.size(), u_mhc_sink_model_m.got.size());
    chk("dac_count", exp_d.size(), u_mhc_sink_model_d.got.size());
    foreach (exp_m[i]) if (skip != 0 && i < u_mhc_sink_model_m.got.size())
      chk("mic_out", exp_m[i], u_mhc_sink_model_m.got[i]);
    foreach (exp_d[i]) if (skip != 1 && i < u_mhc_sink_model_d.got.size())
      chk("dac_out", exp_d[i], u_mhc_sink_model_d.got[i]);
    if (skip == 0 && u_mhc_sink_model_m.got.size() > 0)
      {first, last} = {u_mhc_sink_model_m.got[0], u_mhc_sink_model_m.got[$]};
    if (skip == 1 && u_mhc_sink_model_d.got.size() > 0)
      {first, last} = {u_mhc_sink_model_d.got[0], u_mhc_sink_model_d.got[$]};
    exp_m.delete();
    exp_d.delete();
    u_mhc_sink_model_m.got.delete();
    u_mhc_sink_model_d.got.delete();
  endtask

  initial begin
    void'($urandom(32'h716787eb));
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rdc("mic_filter", A_F, 32'h10);
    rdc("cmp_main", A_M, 32'h0);
    rdc("cmp_slope", A_S, 32'h0);
    rdc("cmp_knee", A_K, 32'h0);
    apb(1'b0, 8'h04, 32'h0);
    chk("unmapped_err", 32'h1, er);
    chk("unmapped_rd", 32'h0, rd);
    for (int i = 0; i < 8; i++) begin
      x = $urandom;
      apb(1'b1, A_S, x & 16'h003F);
      rdc("cmp_slope", A_S, x & 16'h003F);
      apb(1'b1, A_K, x & 16'h07FF);
      rdc("cmp_knee", A_K, x & 16'h07FF);
    end
    // Everything off: both paths bit-exact under back-pressure
    apb(1'b1, A_F, 32'h0);
    apb(1'b1, A_M, 32'h0);
    stall <= 1'b1;
    for (int i = 0; i < 24; i++) snd(i[0], 16'($urandom));
    drain(2);
    // Stalled sink: FIFO takes exactly its depth, then refuses
    hold_m <= 1'b1;
    repeat (2) @(posedge pclk);
    for (int i = 0; i < 8; i++) begin
      x = $urandom;
      mic_in_valid <= 1'b1;
      mic_in_data <= x;
      @(posedge pclk);
      if (mic_in_ready === 1'b1) exp_m.push_back(x);
    end
    chk("fifo_fill", mhc_pkg::FIFO_DEPTH, exp_m.size());
    hold_m <= 1'b0;
    drain(2);
    // Loud tone on the selected path, random on the other; p=1 uses reserved codes
    for (int p = 0; p < 2; p++) begin
      apb(1'b1, A_S, p ? 32'h38 : 32'h28);
      apb(1'b1, A_K, p ? 32'h7F0 : 32'h790);
      apb(1'b1, A_M, 32'h8000 | (p << 14));
      rdc("cmp_main", A_M, 32'h8000 | (p << 14));
      for (int i = 0; i < 300; i++) begin
        snd(p[0], 16'h7000);
        snd(!p[0], 16'($urandom));
      end
      drain(p);
      chkr("compressed", 2048.0, 16384.0, last);
    end
    apb(1'b1, A_M, 32'h4000);
    for (int i = 0; i < 8; i++) snd(i[0], 16'h7000);
    drain(2);
    // Constant input through each cutoff
    stall <= 1'b0;
    for (int c = 0; c < 4; c++) begin
      apb(1'b1, A_F, 32'h0);
      apb(1'b1, A_F, 32'h10 | (c << 5));
      for (int i = 0; i < 64; i++) snd(1'b0, 16'h0FA0);
      drain(0);
      chk("hpf_first", 32'h0FA0, first);
      e = 4000.0 * (1.0 - 1.0 / (1 << mhc_pkg::HPF_SHIFT[c])) ** 63;
      chkr("hpf_last", e - 10.0 - e / 50.0, e + 10.0 + e / 50.0, last);
    end
    // Silence on a fresh history stays silent
    apb(1'b1, A_F, 32'h0);
    apb(1'b1, A_F, 32'h10);
    for (int i = 0; i < 4; i++) snd(1'b0, 16'h0000);
    drain(0);
    chk("hpf_zero", 32'h0, last);
    final_report();
  end
endmodule
